// ==== core/lhcr_pkg.sv ====
package lhcr_pkg;

    // Register byte offsets
    localparam logic [11:0] LHCR_SET_OFS = 12'h050;
    localparam logic [11:0] LHCR_CLR_OFS = 12'h054;

    // Control bit positions
    localparam int LHCR_SWAP_BIT = 30;
    localparam int LHCR_PERM_BIT = 23;
    localparam int LHCR_ENH_BIT = 22;
    localparam int LHCR_LPS_BIT = 19;
    localparam int LHCR_POST_BIT = 18;
    localparam int LHCR_LINK_BIT = 17;
    localparam int LHCR_SRST_BIT = 16;

    // Implemented bits; all others read zero
    localparam logic [31:0] LHCR_IMPL_MASK = 32'h40CF_0000;

    // Reset values of the control fields
    localparam logic LHCR_SWAP_RST = 1'b0;
    localparam logic LHCR_POST_RST = 1'b0;
    localparam logic LHCR_CTRL_RST = 1'b0;

    // Cycles the soft reset spends in LHCR_BUSY; it stays in progress one cycle longer
    localparam logic [7:0] LHCR_SRST_CYCLES = 8'h10;

    // Control outputs toward the link logic
    typedef struct packed {
        logic dataSwap;
        logic phyConfigPermission;
        logic phyEnhancementUse;
        logic linkPowerStatus;
        logic postedWriteAllow;
        logic linkActive;
        logic busConnected;
    } lhcr_ctrl_s;

    // Soft reset sequencer states
    typedef enum logic [1:0] {
        LHCR_IDLE,
        LHCR_BUSY,
        LHCR_DONE
    } lhcr_srst_e;

endpackage

// ==== core/lhcr_soft_reset.sv ====
`timescale 1ns/1ps
`default_nettype none
module lhcr_soft_reset
    import lhcr_pkg::*;
#(
    parameter logic [7:0] CYCLES = LHCR_SRST_CYCLES
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic startPulse,
    output logic busy,
    output logic flushPulse
);
    // Sequencer state and its counter
    lhcr_srst_e state_reg;
    logic [7:0] count_reg;

    // Counts out the reset; a new start while busy is ignored
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= LHCR_IDLE;
            count_reg <= 8'h00;
        end else begin
            case (state_reg)
                LHCR_IDLE: begin
                    if (startPulse) begin
                        state_reg <= LHCR_BUSY;
                        count_reg <= CYCLES;
                    end
                end
                LHCR_BUSY: begin
                    // Counter reaching one ends the reset
                    if (count_reg <= 8'h01) begin
                        state_reg <= LHCR_DONE;
                    end else begin
                        count_reg <= count_reg - 8'h01;
                    end
                end
                default: begin
                    state_reg <= LHCR_IDLE;
                end
            endcase
        end
    end

    assign busy = (state_reg != LHCR_IDLE);
    // Flush strobe on entry so FIFOs empty early in the reset
    assign flushPulse = (state_reg == LHCR_IDLE) && startPulse;
endmodule
`default_nettype wire

// ==== core/lhcr_top.sv ====
// Notes on behaviour
// - Set at 50h, clear at 54h, shared state
// - Reserved bits always read as zero
// - Bit 30 selects DMA data byte swap
// - Bit 23 permission, loadable from EEPROM
// - Bit 19 gates link to PHY traffic
// - Bit 18 enables posting of writes
// - Link active cleared by any reset
// - Software link clear disconnects bus immediately
// - Soft reset clears state and FIFOs
// - Soft reset bit reads one while busy
`timescale 1ns/1ps
`default_nettype none
module lhcr_top
    import lhcr_pkg::*;
#(
    parameter logic [7:0] SRST_CYCLES = LHCR_SRST_CYCLES
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic eepromValid,
    input wire logic eepromPermission,
    output lhcr_pkg::lhcr_ctrl_s ctrlOut,
    output logic fifoFlush,
    output logic linkStateReset
);
    import lhcr_pkg::*;

    // Control bits
    logic swap_reg;
    logic perm_reg;
    logic enh_reg;
    logic lps_reg;
    logic post_reg;
    logic link_reg;
    // Synchronised EEPROM strobe, two stages
    logic eeValidMeta_reg;
    logic eeValid_reg;
    logic eePermMeta_reg;
    logic eePerm_reg;
    // Soft reset sequencer wiring
    logic srstBusy;
    logic srstFlush;
    logic srstStart;
    logic [31:0] readValue;

    // Access phase decode, answered the same cycle
    logic access;
    logic wrSet;
    logic wrClr;
    logic hit;
    assign access = psel && penable;
    assign hit = (paddr == LHCR_SET_OFS) || (paddr == LHCR_CLR_OFS);
    assign wrSet = access && pwrite && (paddr == LHCR_SET_OFS);
    assign wrClr = access && pwrite && (paddr == LHCR_CLR_OFS);

    // Returns the written bit at a given position
    function automatic logic wbit(input logic [31:0] d, input int pos);
        return d[pos];
    endfunction

    // Soft reset is only started through the set register
    assign srstStart = wrSet && wbit(pwdata, LHCR_SRST_BIT);

    lhcr_soft_reset #(
        .CYCLES(SRST_CYCLES)
    ) u_srst (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .startPulse(srstStart),
        .busy(srstBusy),
        .flushPulse(srstFlush)
    );

    // EEPROM straps come from outside; synchronise before use
    // Only the second stage of each pair is read by control logic
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            eeValidMeta_reg <= 1'b0;
            eeValid_reg <= 1'b0;
            eePermMeta_reg <= 1'b0;
            eePerm_reg <= 1'b0;
        end else begin
            eeValidMeta_reg <= eepromValid;
            eeValid_reg <= eeValidMeta_reg;
            eePermMeta_reg <= eepromPermission;
            eePerm_reg <= eePermMeta_reg;
        end
    end

    // Byte swap control; soft reset restores its reset value
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            swap_reg <= LHCR_SWAP_RST;
        end else if (srstBusy) begin
            swap_reg <= LHCR_SWAP_RST;
        end else if (wrSet && wbit(pwdata, LHCR_SWAP_BIT)) begin
            swap_reg <= 1'b1;
        end else if (wrClr && wbit(pwdata, LHCR_SWAP_BIT)) begin
            swap_reg <= 1'b0;
        end
    end

    // Permission: loaded from EEPROM, cleared by software only
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            perm_reg <= LHCR_CTRL_RST;
        end else if (eeValid_reg) begin
            // The load is a hardware set and wins over a clear
            perm_reg <= eePerm_reg;
        end else if (wrClr && wbit(pwdata, LHCR_PERM_BIT)) begin
            perm_reg <= 1'b0;
        end
    end

    // Enhancement use; driver discipline keeps it legal
    // Permission and link state are not checked here, by intent
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            enh_reg <= LHCR_CTRL_RST;
        end else if (srstBusy) begin
            enh_reg <= LHCR_CTRL_RST;
        end else if (wrSet && wbit(pwdata, LHCR_ENH_BIT)) begin
            enh_reg <= 1'b1;
        end else if (wrClr && wbit(pwdata, LHCR_ENH_BIT)) begin
            enh_reg <= 1'b0;
        end
    end

    // Link power status gates PHY traffic
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lps_reg <= LHCR_CTRL_RST;
        end else if (srstBusy) begin
            lps_reg <= LHCR_CTRL_RST;
        end else if (wrSet && wbit(pwdata, LHCR_LPS_BIT)) begin
            lps_reg <= 1'b1;
        end else if (wrClr && wbit(pwdata, LHCR_LPS_BIT)) begin
            lps_reg <= 1'b0;
        end
    end

    // Posted write enable; not qualified by link state in hardware
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            post_reg <= LHCR_POST_RST;
        end else if (srstBusy) begin
            post_reg <= LHCR_POST_RST;
        end else if (wrSet && wbit(pwdata, LHCR_POST_BIT)) begin
            post_reg <= 1'b1;
        end else if (wrClr && wbit(pwdata, LHCR_POST_BIT)) begin
            post_reg <= 1'b0;
        end
    end

    // Link active: forced low by both resets; set blocked while busy
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            link_reg <= 1'b0;
        end else if (srstBusy || srstStart) begin
            link_reg <= 1'b0;
        end else if (wrSet && wbit(pwdata, LHCR_LINK_BIT)) begin
            link_reg <= 1'b1;
        end else if (wrClr && wbit(pwdata, LHCR_LINK_BIT)) begin
            link_reg <= 1'b0;
        end
    end

    // Read image; unlisted bits stay zero by the mask
    always_comb begin
        readValue = 32'h0000_0000;
        readValue[LHCR_SWAP_BIT] = swap_reg;
        readValue[LHCR_PERM_BIT] = perm_reg;
        readValue[LHCR_ENH_BIT] = enh_reg;
        readValue[LHCR_LPS_BIT] = lps_reg;
        readValue[LHCR_POST_BIT] = post_reg;
        readValue[LHCR_LINK_BIT] = link_reg;
        readValue[LHCR_SRST_BIT] = srstBusy;
        readValue = readValue & LHCR_IMPL_MASK;
    end

    // APB answer: no wait states; ready and data from flops
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            // Setup phase: prepare the answer for the access phase
            pready <= 1'b1;
            pslverr <= !hit;
            if (!pwrite && hit) begin
                prdata <= readValue;
            end else begin
                prdata <= 32'h0000_0000;
            end
        end else begin
            // Access or idle: the answer stands for one cycle only
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Control outputs, registered so they are clean flops
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrlOut <= '0;
            fifoFlush <= 1'b0;
            linkStateReset <= 1'b0;
        end else begin
            ctrlOut.dataSwap <= swap_reg;
            ctrlOut.phyConfigPermission <= perm_reg;
            ctrlOut.phyEnhancementUse <= enh_reg;
            ctrlOut.linkPowerStatus <= lps_reg;
            ctrlOut.postedWriteAllow <= post_reg;
            ctrlOut.linkActive <= link_reg;
            // Disconnect immediately, not waiting on the flop copy
            ctrlOut.busConnected <= link_reg && !(wrClr && wbit(pwdata, LHCR_LINK_BIT));
            fifoFlush <= srstFlush;
            linkStateReset <= srstBusy || srstStart;
        end
    end

    // Assertions: each one guards the logic above it by name
    // Setup phase of an APB transfer as this slave sees it
    sequence apbSetup_s;
        psel && !penable;
    endsequence

    // Soft reset start; a start while busy is not a new start
    sequence srstBegin_s;
        srstStart && !srstBusy;
    endsequence

    // Soft reset in progress: link held low, state reset shown
    sequence srstHold_s;
        srstBusy && !link_reg && linkStateReset;
    endsequence

    // Checked on the bus output, so a decode slip cannot hide it
    reservedZero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (prdata & ~LHCR_IMPL_MASK) == 32'h0000_0000)
        else $error("reserved bit read nonzero");
    // Only the strap load may raise permission
    permNoSet_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!perm_reg && !eeValid_reg) |=> !perm_reg)
        else $error("permission set by software");
    // Software clear lands when no strap load is pending
    permClr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wrClr && pwdata[LHCR_PERM_BIT] && !eeValid_reg |=> !perm_reg)
        else $error("permission clear lost");
    // The strap value lands one cycle after the synced strobe
    eeLoad_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        eeValid_reg |=> perm_reg == $past(eePerm_reg))
        else $error("EEPROM load lost");
    // Link stays low while the reset starts
    linkReset_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        srstStart |=> !link_reg [*3])
        else $error("link active during soft reset");
    // Link set lands in the flop and reaches the output a cycle later
    linkSet_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wrSet && pwdata[LHCR_LINK_BIT] && !pwdata[LHCR_SRST_BIT] && !srstBusy
            |=> link_reg ##1 ctrlOut.linkActive)
        else $error("link set lost");
    // An inactive link never shows a connected bus
    disconnect_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !link_reg |=> !ctrlOut.busConnected)
        else $error("bus connected while link inactive");
    // Clearing the link drops the bus at the same edge as the flop
    dropNow_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wrClr && pwdata[LHCR_LINK_BIT] |=> !ctrlOut.busConnected)
        else $error("bus dropped late");
    // Bit 16 reads one for the first cycles of the reset
    srstReads_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        srstStart && !srstBusy |=> readValue[LHCR_SRST_BIT] [*8])
        else $error("soft reset bit dropped early");
    // The reset ends by itself within 300 cycles, past the counter range
    srstEnds_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(srstBusy) |-> ##[1:300] !srstBusy)
        else $error("soft reset never completes");
    // Start, then two cycles with the link held inactive
    srstSteps_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        srstBegin_s |=> srstHold_s ##1 srstHold_s)
        else $error("soft reset steps out of order");
    // Flush strobe follows the start and lasts one cycle
    flushStart_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        srstBegin_s |=> fifoFlush ##1 !fifoFlush)
        else $error("flush strobe wrong");
    // Controls other than permission sit at their reset values from the second cycle of the reset until one cycle after it
    ctrlHeld_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        srstBusy |=> swap_reg == LHCR_SWAP_RST && post_reg == LHCR_POST_RST
            && enh_reg == LHCR_CTRL_RST && lps_reg == LHCR_CTRL_RST && !link_reg)
        else $error("control changed during soft reset");
    // Power status set reaches both the flop and the output
    lpsSet_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wrSet && pwdata[LHCR_LPS_BIT] && !srstBusy |=> lps_reg ##1 ctrlOut.linkPowerStatus)
        else $error("power status set lost");
    // Posting clear reaches both the flop and the output
    postClr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wrClr && pwdata[LHCR_POST_BIT] && !wrSet |=> !post_reg ##1 !ctrlOut.postedWriteAllow)
        else $error("posting clear lost");
    // Swap set lands in the flop
    swapSet_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wrSet && pwdata[LHCR_SWAP_BIT] && !srstBusy |=> swap_reg)
        else $error("swap set lost");
    // Enhancement clear lands in the flop
    enhClr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wrClr && pwdata[LHCR_ENH_BIT] |=> !enh_reg)
        else $error("enhancement clear lost");
    // Read data is the image captured in the setup cycle
    readBack_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        psel && !penable && !pwrite && hit |=> prdata == $past(readValue))
        else $error("read data mismatch");
    // Every setup is answered in the next cycle, no further waits
    readyNext_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        apbSetup_s |=> pready)
        else $error("ready missing after setup");
    // Ready stands one cycle, so a write cannot land twice
    readyPulse_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pready |=> !pready)
        else $error("ready held too long");
    // Unmapped addresses answer with an error, mapped ones without
    errResp_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        psel && !penable && !hit |=> pslverr)
        else $error("unmapped access not flagged");
    okResp_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        psel && !penable && hit |=> !pslverr)
        else $error("mapped access flagged");
endmodule
`default_nettype wire

// ==== dv/lhcr_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module lhcr_top_bench;
    import lhcr_pkg::*;

    // Short soft reset keeps the run brief
    localparam logic [7:0] SRST_LEN = 8'h08;

    logic sys_clk; // Core clock
    logic sys_rst; // Async reset, active high
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic eepromValid; // Strap that loads the permission bit
    logic eepromPermission;
    lhcr_ctrl_s ctrlOut;
    logic fifoFlush;
    logic linkStateReset;
    int n_errors; // Mismatches seen
    int n_checks; // Comparisons made
    int flushCnt; // Flush pulses seen since start

    lhcr_top #(.SRST_CYCLES(SRST_LEN)) dut_u (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .eepromValid(eepromValid), .eepromPermission(eepromPermission), .ctrlOut(ctrlOut),
        .fifoFlush(fifoFlush), .linkStateReset(linkStateReset)
    );

    // Free running clock, 4 ns period
    always #2 sys_clk = ~sys_clk;

    // Count flush pulses so a double pulse is caught too
    always @(posedge sys_clk) begin
        if (fifoFlush === 1'b1) begin
            flushCnt <= flushCnt + 1;
        end
    end

    // Verdict and end of run, the only exit
    task automatic end_sim();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Single compare for every kind of result
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int i;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        if (i == 50) begin
            n_errors++;
            end_sim();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Write, checking the error response against the expected one
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic expErr);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk({31'h00000000, e}, {31'h00000000, expErr});
    endtask

    // Read and compare the returned word
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h00000000, r, e);
        chk(r, exp);
    endtask

    // Lets the one-cycle lag of the control outputs pass
    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    // Both views read zero after hardware reset
    task automatic t_reset();
        rd(LHCR_SET_OFS, 32'h00000000);
        rd(LHCR_CLR_OFS, 32'h00000000);
    endtask

    // All ones but bits 22 and 16 through set: reserved bits and permission stay zero
    task automatic t_set_all();
        wr(LHCR_SET_OFS, 32'hFFBEFFFF, 1'b0);
        rd(LHCR_SET_OFS, 32'h400E0000);
        rd(LHCR_CLR_OFS, 32'h400E0000);
        settle();
        chk({25'h0000000, ctrlOut}, 32'h0000004F);
    endtask

    // Clear one bit, then the link bit and watch the bus connection drop, then all but bit 22
    task automatic t_clear();
        wr(LHCR_CLR_OFS, 32'h00080000, 1'b0);
        rd(LHCR_SET_OFS, 32'h40060000);
        wr(LHCR_CLR_OFS, 32'h00020000, 1'b0);
        settle();
        chk({31'h00000000, ctrlOut.busConnected}, 32'h00000000);
        wr(LHCR_CLR_OFS, 32'hFFBFFFFF, 1'b0);
        rd(LHCR_CLR_OFS, 32'h00000000);
    endtask

    // Unmapped place: error response, no effect, reads zero
    task automatic t_unmapped();
        wr(12'h058, 32'hFFFFFFFF, 1'b1);
        rd(12'h058, 32'h00000000);
        rd(LHCR_SET_OFS, 32'h00000000);
    endtask

    // Permission loaded from the strap, clearable but never settable
    task automatic t_perm();
        @(posedge sys_clk);
        eepromPermission <= 1'b1;
        eepromValid <= 1'b1;
        repeat (4) @(posedge sys_clk);
        eepromValid <= 1'b0;
        rd(LHCR_SET_OFS, 32'h00800000);
        wr(LHCR_SET_OFS, 32'h00020000, 1'b0);
        wr(LHCR_SET_OFS, 32'h00400000, 1'b0);
        rd(LHCR_SET_OFS, 32'h00C20000);
        chk({25'h0000000, ctrlOut}, 32'h00000033);
        wr(LHCR_CLR_OFS, 32'h00C20000, 1'b0);
        rd(LHCR_SET_OFS, 32'h00000000);
        wr(LHCR_SET_OFS, 32'h00800000, 1'b0);
        rd(LHCR_SET_OFS, 32'h00000000);
    endtask

    // Soft reset: bit reads one while busy, clears controls, clears itself
    task automatic t_soft();
        int i;
        logic [31:0] r;
        logic e;
        wr(LHCR_SET_OFS, 32'h400E0000, 1'b0);
        wr(LHCR_SET_OFS, 32'h00010000, 1'b0);
        rd(LHCR_SET_OFS, 32'h00010000);
        chk({31'h00000000, linkStateReset}, 32'h00000001);
        chk({31'h00000000, ctrlOut.linkActive}, 32'h00000000);
        // Writes while busy are refused, including a clear of the busy bit
        wr(LHCR_CLR_OFS, 32'h00010000, 1'b0);
        wr(LHCR_SET_OFS, 32'h00080000, 1'b0);
        for (i = 0; i < 40; i++) begin
            apb(1'b0, LHCR_SET_OFS, 32'h00000000, r, e);
            if (r[LHCR_SRST_BIT] !== 1'b1) break;
        end
        if (i == 40) begin
            n_errors++;
            end_sim();
        end
        chk(r, 32'h00000000);
        chk({31'h00000000, linkStateReset}, 32'h00000000);
        chk(32'(flushCnt), 32'h00000001);
    endtask

    // Main sequence
    initial begin
        sys_clk = 1'b0;
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        eepromValid = 1'b0;
        eepromPermission = 1'b0;
        n_errors = 0;
        n_checks = 0;
        flushCnt = 0;
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_set_all();
        t_clear();
        t_unmapped();
        t_perm();
        t_soft();
        end_sim();
    end
endmodule
`default_nettype wire
